//--- design/ckr_pkg.sv
package ckr_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OUTPUT_SKEW_CONTROL_OFS           = 8'h0a;
    localparam logic [7:0] RECOVERY_N_DIVIDER_OFS            = 8'h0b;
    localparam logic [7:0] RECOVERY_M_DIVIDER_AND_SOURCE_OFS = 8'h0c;
    localparam logic [7:0] PROGRAMMABLE_N_DIVIDER_OFS        = 8'h0d;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] OUTPUT_SKEW_CONTROL_RST           = 8'h00;
    localparam logic [7:0] RECOVERY_N_DIVIDER_RST            = 8'h00;
    localparam logic [7:0] RECOVERY_M_DIVIDER_AND_SOURCE_RST = 8'h00;
    localparam logic [7:0] PROGRAMMABLE_N_DIVIDER_RST        = 8'h00;
    localparam logic [7:0] UNMAPPED_READ_VAL                 = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CPU_SKEW_LSB   = 5;
    localparam int CPU_SKEW_W     = 3;
    localparam int GFX_SKEW_LSB   = 0;
    localparam int GFX_SKEW_W     = 2;
    localparam int REC_SRC_BIT    = 7;
    localparam int N_W            = 8;
    localparam int M_W            = 7;
    localparam int RATIO_W        = 5;
    localparam logic [7:0] SKEW_WRITE_MASK = 8'he3;

    // ------------------------------------------------------------
    // programmable frequency span and sampling
    // ------------------------------------------------------------
    localparam int FREQ_MIN_MHZ   = 50;
    localparam int FREQ_MAX_MHZ   = 248;
    localparam int SYNC_STAGES    = 2;

    // ------------------------------------------------------------
    // output frequency modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CKR_MODE_STRAP,
        CKR_MODE_PROG,
        CKR_MODE_RECOVERY
    } ckr_mode_e;
endpackage : ckr_pkg

//--- design/ckr_sync.sv
`timescale 1ns/1ps
module ckr_sync
    import ckr_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             rst,
    // data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    // width check at elaboration
    if (WIDTH < 1) begin : g_width_chk
        $error("ckr_sync: WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;

    // two-flop synchroniser, first stage read only by second
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stage1_r <= '0;
            stage2_r <= '0;
        end else begin
            stage1_r <= async_in;
            stage2_r <= stage1_r;
        end
    end

    assign sync_out = stage2_r;
endmodule : ckr_sync

//--- design/ckr_freq_regs.sv
`timescale 1ns/1ps
// Function
// (RL1) cpu skew code: 000 nominal, 001-011 earlier, 100-111 later in 150 ps steps.
// (RL2) graphics skew code: 00 nominal, 01 -150, 10 +150, 11 +300 ps.
// (RL3) recovery source bit: 0 uses latched straps, 1 uses recovery n and m.
// (RL4) watchdog time-out switches cpu output to recovery frequency automatically.
// (RL5) source bit set: recovery frequency from 8-bit n and 7-bit m.
// (RL6) frequency ratio from straps unless override set, then from software select.
// (RL7) programmable span 50 to 248 mhz; software keeps n and m inside it.
// (RL8) writing recovery n or recovery m alone starts a frequency change.
// (RL9) host should write recovery n and m in one word or block write.
// (RL10) programmable enable set: cpu frequency from programmable n and m.
// (RL11) only a programmable m write loads new frequency; n write alone does not.
// (RL12) after time-out lock in recovery, ignore frequency writes until run bit cleared.
// (RL13) programmable enable clear: programmed n and m never set cpu frequency.
// (RL14) time-out event arrives from external watchdog counter and applies recovery.
module ckr_freq_regs
    import ckr_pkg::*;
(
    // clock and reset
    input  wire logic               mclk,
    input  wire logic               rst,
    // register port from serial engine, on its own clock
    input  wire logic               smb_clk,
    input  wire logic               smb_wr_en,
    input  wire logic [7:0]         smb_addr,
    input  wire logic [7:0]         smb_wdata,
    output logic      [7:0]         smb_rdata,
    output logic                    smb_hit,
    // neighbouring control bits and events, same clock
    input  wire logic               watchdog_timeout,
    input  wire logic               watchdog_run_bit,
    input  wire logic               prog_freq_enable,
    input  wire logic [M_W-1:0]     prog_m_value,
    input  wire logic               prog_m_wr,
    input  wire logic               strap_override,
    input  wire logic [RATIO_W-1:0] strap_freq_select,
    input  wire logic [RATIO_W-1:0] sw_freq_select,
    // synthesizer controls
    output logic [CPU_SKEW_W-1:0]   cpu_clock_skew,
    output logic [GFX_SKEW_W-1:0]   graphics_clock_skew,
    output logic [RATIO_W-1:0]      ratio_select,
    output logic                    freq_from_nm,
    output logic [N_W-1:0]          freq_n,
    output logic [M_W-1:0]          freq_m,
    output logic                    freq_load,
    output logic                    recovery_locked
);
    // ------------------------------------------------------------
    // register port crossing
    // ------------------------------------------------------------
    logic        smb_clk_s;
    logic        smb_wr_s;
    logic [7:0]  smb_addr_s;
    logic [7:0]  smb_wdata_s;
    logic        smb_clk_d_r;

    ckr_sync #(.WIDTH(18)) u_sync (
        .mclk     (mclk),
        .rst      (rst),
        .async_in ({smb_clk, smb_wr_en, smb_addr, smb_wdata}),
        .sync_out ({smb_clk_s, smb_wr_s, smb_addr_s, smb_wdata_s})
    );

    // previous synced link clock for edge finding
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            smb_clk_d_r <= 1'b0;
        end else begin
            smb_clk_d_r <= smb_clk_s;
        end
    end

    logic wr_stb;
    assign wr_stb = smb_clk_s & ~smb_clk_d_r & smb_wr_s;

    // address match helper
    function automatic logic hit_at(input logic [7:0] a, input logic [7:0] ofs);
        hit_at = (a == ofs);
    endfunction : hit_at

    logic wr_skew;
    logic wr_rec_n;
    logic wr_rec_m;
    logic wr_prog_n;
    assign wr_skew   = wr_stb & hit_at(smb_addr_s, OUTPUT_SKEW_CONTROL_OFS);
    assign wr_rec_n  = wr_stb & hit_at(smb_addr_s, RECOVERY_N_DIVIDER_OFS);
    assign wr_rec_m  = wr_stb & hit_at(smb_addr_s, RECOVERY_M_DIVIDER_AND_SOURCE_OFS);
    assign wr_prog_n = wr_stb & hit_at(smb_addr_s, PROGRAMMABLE_N_DIVIDER_OFS);

    // ------------------------------------------------------------
    // register bank
    // ------------------------------------------------------------
    logic [7:0] skew_r, skew_nxt;
    logic [7:0] rec_n_r, rec_n_nxt;
    logic [7:0] rec_m_r, rec_m_nxt;
    logic [7:0] prog_n_r, prog_n_nxt;
    logic       locked_r, locked_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic       hit_r, hit_nxt;

    // next register values, frequency bytes frozen while locked
    always_comb begin
        skew_nxt   = skew_r;
        rec_n_nxt  = rec_n_r;
        rec_m_nxt  = rec_m_r;
        prog_n_nxt = prog_n_r;
        if (wr_skew) begin
            skew_nxt = smb_wdata_s & SKEW_WRITE_MASK; // reserved bits stay zero
        end
        if (wr_rec_n && !locked_r) begin // RL12
            rec_n_nxt = smb_wdata_s;
        end
        if (wr_rec_m && !locked_r) begin // RL12
            rec_m_nxt = smb_wdata_s;
        end
        if (wr_prog_n && !locked_r) begin // RL12
            prog_n_nxt = smb_wdata_s;
        end
        // time-out sets lock and wins over the unlock
        if (watchdog_timeout) begin // RL12
            locked_nxt = 1'b1;
        end else if (!watchdog_run_bit) begin
            locked_nxt = 1'b0;
        end else begin
            locked_nxt = locked_r;
        end
        // read mux
        hit_nxt = 1'b1;
        case (smb_addr_s)
            OUTPUT_SKEW_CONTROL_OFS:           rdata_nxt = skew_r;
            RECOVERY_N_DIVIDER_OFS:            rdata_nxt = rec_n_r;
            RECOVERY_M_DIVIDER_AND_SOURCE_OFS: rdata_nxt = rec_m_r;
            PROGRAMMABLE_N_DIVIDER_OFS:        rdata_nxt = prog_n_r;
            default: begin
                rdata_nxt = UNMAPPED_READ_VAL;
                hit_nxt   = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            skew_r   <= OUTPUT_SKEW_CONTROL_RST;
            rec_n_r  <= RECOVERY_N_DIVIDER_RST;
            rec_m_r  <= RECOVERY_M_DIVIDER_AND_SOURCE_RST;
            prog_n_r <= PROGRAMMABLE_N_DIVIDER_RST;
            locked_r <= 1'b0;
            rdata_r  <= UNMAPPED_READ_VAL;
            hit_r    <= 1'b0;
        end else begin
            skew_r   <= skew_nxt;
            rec_n_r  <= rec_n_nxt;
            rec_m_r  <= rec_m_nxt;
            prog_n_r <= prog_n_nxt;
            locked_r <= locked_nxt;
            rdata_r  <= rdata_nxt;
            hit_r    <= hit_nxt;
        end
    end

    // ------------------------------------------------------------
    // frequency target selection
    // ------------------------------------------------------------
    logic             rec_src;
    ckr_mode_e        mode_r, mode_nxt;
    logic [N_W-1:0]   n_r, n_nxt;
    logic [M_W-1:0]   m_r, m_nxt;
    logic             nm_r, nm_nxt;
    logic             load_r, load_nxt;
    logic [RATIO_W-1:0] ratio_r, ratio_nxt;

    assign rec_src = rec_m_r[REC_SRC_BIT]; // RL3

    // picks the active source and raises a load pulse on retarget
    always_comb begin
        mode_nxt = mode_r;
        n_nxt    = n_r;
        m_nxt    = m_r;
        nm_nxt   = nm_r;
        load_nxt = 1'b0;
        // strap ratio unless overridden by software select
        ratio_nxt = strap_override ? sw_freq_select : strap_freq_select; // RL6
        if (watchdog_timeout) begin // RL4 RL14
            mode_nxt = CKR_MODE_RECOVERY;
            n_nxt    = rec_n_r; // RL5
            m_nxt    = rec_m_r[M_W-1:0];
            nm_nxt   = rec_src; // RL3
            load_nxt = 1'b1;
        end else if (!locked_r) begin // RL12
            case (mode_r)
                CKR_MODE_STRAP, CKR_MODE_RECOVERY: begin
                    if (wr_rec_n || wr_rec_m) begin // RL8
                        mode_nxt = CKR_MODE_RECOVERY;
                        n_nxt    = wr_rec_n ? smb_wdata_s : rec_n_r;
                        m_nxt    = wr_rec_m ? smb_wdata_s[M_W-1:0] : rec_m_r[M_W-1:0];
                        nm_nxt   = wr_rec_m ? smb_wdata_s[REC_SRC_BIT] : rec_src;
                        load_nxt = 1'b1;
                    end else if (prog_m_wr && prog_freq_enable) begin // RL11 RL13
                        mode_nxt = CKR_MODE_PROG;
                        n_nxt    = prog_n_r; // RL10
                        m_nxt    = prog_m_value;
                        nm_nxt   = 1'b1;
                        load_nxt = 1'b1;
                    end
                end
                CKR_MODE_PROG: begin
                    if (!prog_freq_enable) begin // RL13
                        mode_nxt = CKR_MODE_STRAP;
                        nm_nxt   = 1'b0;
                        load_nxt = 1'b1;
                    end else if (prog_m_wr) begin // RL11
                        n_nxt    = prog_n_r; // RL10
                        m_nxt    = prog_m_value;
                        load_nxt = 1'b1;
                    end else if (wr_rec_n || wr_rec_m) begin // RL8
                        mode_nxt = CKR_MODE_RECOVERY;
                        n_nxt    = wr_rec_n ? smb_wdata_s : rec_n_r;
                        m_nxt    = wr_rec_m ? smb_wdata_s[M_W-1:0] : rec_m_r[M_W-1:0];
                        nm_nxt   = wr_rec_m ? smb_wdata_s[REC_SRC_BIT] : rec_src;
                        load_nxt = 1'b1;
                    end
                end
                default: begin
                    mode_nxt = CKR_MODE_STRAP;
                    nm_nxt   = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mode_r  <= CKR_MODE_STRAP;
            n_r     <= '0;
            m_r     <= '0;
            nm_r    <= 1'b0;
            load_r  <= 1'b0;
            ratio_r <= '0;
        end else begin
            mode_r  <= mode_nxt;
            n_r     <= n_nxt;
            m_r     <= m_nxt;
            nm_r    <= nm_nxt;
            load_r  <= load_nxt;
            ratio_r <= ratio_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign cpu_clock_skew      = skew_r[CPU_SKEW_LSB +: CPU_SKEW_W]; // RL1
    assign graphics_clock_skew = skew_r[GFX_SKEW_LSB +: GFX_SKEW_W]; // RL2
    assign ratio_select        = ratio_r;
    assign freq_from_nm        = nm_r;
    assign freq_n              = n_r; // RL7 span kept by software
    assign freq_m              = m_r;
    assign freq_load           = load_r;
    assign recovery_locked     = locked_r;
    assign smb_rdata           = rdata_r;
    assign smb_hit             = hit_r;
endmodule : ckr_freq_regs

//--- testbench/ckr_freq_regs_asserts.sv
`timescale 1ns/1ps
module ckr_freq_regs_asserts
    import ckr_pkg::*;
(
    // clock and reset
    input wire logic               mclk,
    input wire logic               rst,
    // register port
    input wire logic [7:0]         smb_addr,
    input wire logic [7:0]         smb_rdata,
    input wire logic               smb_hit,
    // control bits and events
    input wire logic               watchdog_timeout,
    input wire logic               watchdog_run_bit,
    input wire logic               prog_freq_enable,
    input wire logic [M_W-1:0]     prog_m_value,
    input wire logic               prog_m_wr,
    input wire logic               strap_override,
    input wire logic [RATIO_W-1:0] strap_freq_select,
    input wire logic [RATIO_W-1:0] sw_freq_select,
    // synthesizer controls
    input wire logic [RATIO_W-1:0] ratio_select,
    input wire logic               freq_from_nm,
    input wire logic [M_W-1:0]     freq_m,
    input wire logic               freq_load,
    input wire logic               recovery_locked
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // address decode sequences
    // ------------------------------------------------------------
    sequence mapped_s;
        (smb_addr inside {[8'h0a:8'h0d]}) [*4];
    endsequence
    sequence unmapped_s;
        !(smb_addr inside {[8'h0a:8'h0d]}) [*4];
    endsequence
    sequence skew_sel_s;
        (smb_addr == 8'h0a) [*4];
    endsequence

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    hit_mapped_a: assert property (mapped_s |-> smb_hit)
        else $error("mapped address not flagged");
    unmapped_read_a: assert property (unmapped_s |-> !smb_hit && smb_rdata == 8'h00)
        else $error("unmapped address read not zero");
    skew_reserved_a: assert property (skew_sel_s |-> smb_rdata[4:2] == 3'h0)
        else $error("skew reserved bits not zero");
    timeout_reload_a: assert property (watchdog_timeout |=> freq_load && recovery_locked)
        else $error("time-out did not reload and lock");
    prog_load_a: assert property (prog_m_wr && prog_freq_enable && !recovery_locked
        && !watchdog_timeout |=> freq_load && freq_from_nm && freq_m == $past(prog_m_value))
        else $error("programmed m write did not retarget");
    lock_block_a: assert property (recovery_locked && !watchdog_timeout |=> !freq_load)
        else $error("retarget while locked");
    lock_hold_a: assert property (recovery_locked && watchdog_run_bit |=> recovery_locked)
        else $error("lock dropped with run bit set");
    lock_release_a: assert property (recovery_locked && !watchdog_run_bit
        && !watchdog_timeout |=> !recovery_locked)
        else $error("lock kept with run bit clear");
    ratio_mux_a: assert property (1'b1 |=> ratio_select == ($past(strap_override) ?
        $past(sw_freq_select) : $past(strap_freq_select)))
        else $error("ratio select wrong source");
endmodule : ckr_freq_regs_asserts

bind ckr_freq_regs ckr_freq_regs_asserts ckr_freq_regs_asserts_i (.*);

//--- testbench/ckr_smb_host.sv
`timescale 1ns/1ps
module ckr_smb_host (
    // register port driven by the host
    output logic       smb_clk,
    output logic       smb_wr_en,
    output logic [7:0] smb_addr,
    output logic [7:0] smb_wdata
);
    // idle: clock parked low, no request
    initial begin
        smb_clk = 1'b0;
        smb_wr_en = 1'b0;
        smb_addr = 8'h00;
        smb_wdata = 8'hff;
    end
    // one byte write frame, clock stands still outside it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        smb_addr = a;
        smb_wdata = d;
        smb_wr_en = 1'b1;
        #32 smb_clk = 1'b1;
        #32 smb_clk = 1'b0;
        #32 smb_wr_en = 1'b0;
        smb_wdata = ~d; // data line driven to the complement of the written byte
        #32; // idle gap keeps frames apart
    endtask : wr
    // address only, read data follows it
    task automatic rd(input logic [7:0] a);
        smb_addr = a;
        #40;
    endtask : rd
endmodule : ckr_smb_host

//--- testbench/ckr_freq_regs_test.sv
`timescale 1ns/1ps
module ckr_freq_regs_test;
    import ckr_pkg::*;
    logic mclk, rst, smb_clk, smb_wr_en, smb_hit, freq_from_nm, freq_load, recovery_locked;
    logic watchdog_timeout, watchdog_run_bit, prog_freq_enable, prog_m_wr, strap_override;
    logic [7:0] smb_addr, smb_wdata, smb_rdata, freq_n;
    logic [M_W-1:0] prog_m_value, freq_m;
    logic [RATIO_W-1:0] strap_freq_select, sw_freq_select, ratio_select;
    logic [CPU_SKEW_W-1:0] cpu_clock_skew;
    logic [GFX_SKEW_W-1:0] graphics_clock_skew;
    int n_mismatch = 0;
    int checked = 0;
    int n_load = 0;

    ckr_freq_regs ckr_freq_regs_i (.mclk(mclk), .rst(rst), .smb_clk(smb_clk),
        .smb_wr_en(smb_wr_en), .smb_addr(smb_addr), .smb_wdata(smb_wdata),
        .smb_rdata(smb_rdata), .smb_hit(smb_hit), .watchdog_timeout(watchdog_timeout),
        .watchdog_run_bit(watchdog_run_bit), .prog_freq_enable(prog_freq_enable),
        .prog_m_value(prog_m_value), .prog_m_wr(prog_m_wr), .strap_override(strap_override),
        .strap_freq_select(strap_freq_select), .sw_freq_select(sw_freq_select),
        .cpu_clock_skew(cpu_clock_skew), .graphics_clock_skew(graphics_clock_skew),
        .ratio_select(ratio_select), .freq_from_nm(freq_from_nm), .freq_n(freq_n),
        .freq_m(freq_m), .freq_load(freq_load), .recovery_locked(recovery_locked));
    ckr_smb_host ckr_smb_host_i (.smb_clk(smb_clk), .smb_wr_en(smb_wr_en),
        .smb_addr(smb_addr), .smb_wdata(smb_wdata));

    // clock and retarget pulse count
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    always @(negedge mclk) if (freq_load === 1'b1) n_load++;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask : tick
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        ckr_smb_host_i.rd(a);
        chk(smb_rdata, exp);
    endtask : rdc
    task automatic pm();
        @(negedge mclk) prog_m_wr = 1'b1;
        @(negedge mclk) prog_m_wr = 1'b0;
        tick(2);
    endtask : pm
    task automatic pt();
        @(negedge mclk) watchdog_timeout = 1'b1;
        @(negedge mclk) watchdog_timeout = 1'b0;
        tick(2);
    endtask : pt
    task automatic do_reset();
        @(negedge mclk) rst = 1'b1;
        tick(3);
        rst = 1'b0;
        #200;
    endtask : do_reset

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        for (int i = 0; i < 4; i++) rdc(8'h0a + 8'(i), 8'h00);
        chk(8'(smb_hit), 8'h01);
        rdc(8'h20, 8'h00);
        chk(8'(smb_hit), 8'h00);
        chk(8'(recovery_locked), 8'h00);
        $display("test reset done");
    endtask : t_reset
    task automatic t_skew();
        for (int c = 0; c < 8; c++) begin
            ckr_smb_host_i.wr(8'h0a, {3'(c), 3'b111, 2'(c)});
            chk(8'(cpu_clock_skew), 8'(c));
            chk(8'(graphics_clock_skew), 8'(c % 4));
            rdc(8'h0a, {3'(c), 3'b000, 2'(c)});
        end
        ckr_smb_host_i.wr(8'h20, 8'hff);
        chk(8'(cpu_clock_skew), 8'h07);
        rdc(8'h20, 8'h00);
        $display("test skew done");
    endtask : t_skew
    task automatic t_recov();
        int l;
        l = n_load;
        ckr_smb_host_i.wr(8'h0b, 8'h5a);
        chk(8'(n_load - l), 8'h01);
        chk(freq_n, 8'h5a);
        chk(8'(freq_from_nm), 8'h00);
        ckr_smb_host_i.wr(8'h0c, 8'h93);
        chk(8'(n_load - l), 8'h02);
        chk(8'(freq_m), 8'h13);
        chk(8'(freq_from_nm), 8'h01);
        rdc(8'h0c, 8'h93);
        $display("test recovery done");
    endtask : t_recov
    task automatic t_prog();
        int l;
        l = n_load;
        @(negedge mclk) prog_freq_enable = 1'b1;
        ckr_smb_host_i.wr(8'h0d, 8'h44);
        chk(8'(n_load - l), 8'h00);
        @(negedge mclk) prog_m_value = 7'h21;
        pm();
        chk(8'(n_load - l), 8'h01);
        chk(freq_n, 8'h44);
        chk(8'(freq_m), 8'h21);
        @(negedge mclk) prog_freq_enable = 1'b0;
        tick(2);
        chk(8'(n_load - l), 8'h02);
        chk(8'(freq_from_nm), 8'h00);
        pm();
        chk(8'(n_load - l), 8'h02);
        $display("test programmable done");
    endtask : t_prog
    task automatic t_wdog();
        int l;
        @(negedge mclk) watchdog_run_bit = 1'b1;
        pt();
        l = n_load;
        chk(8'(recovery_locked), 8'h01);
        chk(freq_n, 8'h5a);
        chk(8'(freq_m), 8'h13);
        chk(8'(freq_from_nm), 8'h01);
        ckr_smb_host_i.wr(8'h0b, 8'h11);
        rdc(8'h0b, 8'h5a);
        @(negedge mclk) prog_freq_enable = 1'b1;
        pm();
        chk(8'(n_load - l), 8'h00);
        @(negedge mclk) prog_freq_enable = 1'b0;
        watchdog_run_bit = 1'b0;
        tick(2);
        chk(8'(recovery_locked), 8'h00);
        ckr_smb_host_i.wr(8'h0c, 8'h00);
        @(negedge mclk) prog_freq_enable = 1'b1;
        pm();
        chk(8'(freq_from_nm), 8'h01);
        pt();
        chk(8'(freq_from_nm), 8'h00);
        chk(8'(freq_m), 8'h00);
        $display("test watchdog done");
    endtask : t_wdog
    task automatic t_ratio();
        for (int o = 0; o < 2; o++) begin
            @(negedge mclk) strap_override = 1'(o);
            tick(2);
            chk(8'(ratio_select), (o == 1) ? 8'h0a : 8'h15);
        end
        $display("test ratio done");
    endtask : t_ratio

    // ------------------------------------------------------------
    // verdict, watchdog and main sequence
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    initial begin
        #100000;
        n_mismatch++;
        stop_test();
    end
    initial begin
        {rst, watchdog_timeout, watchdog_run_bit, prog_freq_enable, prog_m_wr} = 5'h10;
        {prog_m_value, strap_override, strap_freq_select, sw_freq_select} = {8'h00, 10'h2aa};
        tick(3);
        rst = 1'b0;
        #200;
        t_reset();
        t_skew();
        t_recov();
        t_prog();
        t_wdog();
        t_ratio();
        do_reset();
        t_reset();
        stop_test();
    end
endmodule : ckr_freq_regs_test
